// >>> verilog/hcss_top.sv
// heading control and carriage skip sequencer with AXI4-Lite registers
// assumes cam, breaker and brush contacts arrive as asynchronous pins
//
// Operation
// [R01] heading mark from second reading sets heading latch, held till feed cam.
// [R02] heading latch sets hold relay and run relay; run holds till cards out.
// [R03] hold relay forces heading card print without list wiring.
// [R04] at third station feed cam, hold relay sets program suspend.
// [R05] suspend blocks program levels, passes unequal and first-card impulses.
// [R06] body relay cannot set while heading cards pass second reading.
// [R07] no repick without mark; hold relay drops at print 190 degrees.
// [R08] body relay sets from clear latch and feed-cycle companion.
// [R09] print cam with hold released and body set issues skip-to-2.
// [R10] request sets all-skips at breaker; then skip start, held till stop.
// [R11] interposer magnet first; clutch only through interposer contact.
// [R12] skip-to-2 stops only on channel 2 hole; stop holds until release.
// [R13] channel 12 hole sets overflow sense and companion until skip ends.
// [R14] last-line relay sets at print cam on last line, held till skip end.
// [R15] overflow only if next card not heading and no skip-to-1 pending.
// [R16] non-indicate relay sets from last line with panel wire, at breaker.
// [R17] skip-to-1 with another skip passes channel 1, stops at other.
// [R18] control tape leaves two spaces after a channel 1 punch.
// [R19] overflow skip clutches through overflow companion at low speed.
// [R20] in combined skip channel 1 sets past-first, enabling channel 2 stop.
// [R21] heading after heading keeps head control, suppresses skip-to-2.
// [R22] missing detail: first-card-minor requests skip-to-1 directly.
// [R23] any all-skips operation suppresses overflow start.
`timescale 1ns/1ns
`include "hcss_defines.svh"
module hcss_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`HCSS_PIN_W-1:0] machine_pins,
    input wire logic program_level_request,
    input wire logic unequal_compare_in,
    input wire logic first_card_in,
    output logic force_print_relay,
    output logic program_level_relays,
    output logic unequal_compare_out,
    output logic first_card_out,
    output logic run_heading_relay,
    output logic speed_interposer_magnet,
    output logic carriage_clutch_magnet,
    output logic high_speed_stop,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    hcss_pkg::hcss_state_t st_q;
    hcss_pkg::hcss_state_t st_d;
    logic [`HCSS_PIN_W-1:0] pins;
    logic [`HCSS_PIN_W-1:0] rise;
    logic [2:0] side_pins;

    // ****************************************************************
    // input synchronisation
    // ****************************************************************
    hcss_pin_sync #(
        .W(`HCSS_PIN_W + 3)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({first_card_in, unequal_compare_in, program_level_request, machine_pins}),
        .pin_out({side_pins, pins})
    );

    assign rise = pins & ~st_q.prev;

    // 1: control, 2: status, 0: unmapped
    function automatic logic [1:0] reg_sel(input logic [7:0] addr);
        if (addr == `HCSS_OFS_CTRL)
        begin
            return 2'h1;
        end
        else if (addr == `HCSS_OFS_STATUS)
        begin
            return 2'h2;
        end
        return 2'h0;
    endfunction

    // ****************************************************************
    // relay sequencing and register bus
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;
        st_d.prev = pins;

        // heading detection, clear first so a same-cycle mark wins
        if (rise[`HCSS_P_CF_RELEASE])
        begin
            st_d.r.heading_seen_latch = 1'b0;
        end
        if (rise[`HCSS_P_HEAD_X] && st_q.ctrl[`HCSS_CTRL_HEAD_EN])
        begin
            st_d.r.heading_seen_latch = 1'b1; // R01
        end
        if (pins[`HCSS_P_CARDS_OUT])
        begin
            st_d.r.run_heading_relay = 1'b0; // R02
        end
        if (rise[`HCSS_P_PM_190] && !st_q.r.heading_seen_latch)
        begin
            st_d.r.heading_hold_relay = 1'b0; // R07
        end
        if (rise[`HCSS_P_CB_HEAD] && st_q.r.heading_seen_latch)
        begin
            st_d.r.heading_hold_relay = 1'b1; // R02 R21
            st_d.r.run_heading_relay = 1'b1; // R02
        end

        // program suspend
        if (rise[`HCSS_P_CB_SUSP_END] && !st_q.r.heading_hold_relay)
        begin
            st_d.r.program_suspend_relay = 1'b0;
        end
        if (rise[`HCSS_P_CF_THIRD] && st_q.r.heading_hold_relay)
        begin
            st_d.r.program_suspend_relay = 1'b1; // R04
        end

        // feed-cycle companion and body card
        if (rise[`HCSS_P_CF_FEED])
        begin
            st_d.r.feed_cycle_companion = !pins[`HCSS_P_MLP]; // R08
        end
        if (st_q.r.heading_seen_latch)
        begin
            st_d.r.body_card_relay = 1'b0; // R06
        end
        if (rise[`HCSS_P_CF_BODY] && !st_q.r.heading_seen_latch
            && st_q.r.feed_cycle_companion)
        begin
            st_d.r.body_card_relay = 1'b1; // R08
        end
        if (st_q.r.heading_hold_relay)
        begin
            st_d.r.skip_two_issued = 1'b0;
        end

        // skip end: stop relays drop every request and hold
        if (st_q.r.high_speed_stop)
        begin
            st_d.r.skip_one_request = 1'b0;
            st_d.r.skip_two_request = 1'b0;
            st_d.r.all_skips_relay = 1'b0;
            st_d.r.skip_start_relay = 1'b0; // R10
            st_d.r.overflow_sense_relay = 1'b0; // R13
            st_d.r.overflow_sense_companion = 1'b0;
            st_d.r.last_line_relay = 1'b0; // R14
            st_d.r.overflow_nonindicate_relay = 1'b0;
            st_d.r.past_first_latch = 1'b0;
        end
        if (rise[`HCSS_P_STOP_REL])
        begin
            st_d.r.high_speed_stop = 1'b0; // R12
        end

        // skip requests
        if (rise[`HCSS_P_PM_SKIP] && !st_q.r.heading_hold_relay && st_q.r.body_card_relay
            && !st_q.r.skip_two_issued)
        begin
            st_d.r.skip_two_request = 1'b1; // R09 R21
            st_d.r.skip_two_issued = 1'b1;
        end
        if (rise[`HCSS_P_FCM])
        begin
            st_d.r.skip_one_request = 1'b1; // R22
        end

        // overflow
        if (rise[`HCSS_P_CARR_CB] && pins[`HCSS_P_BRUSH12])
        begin
            st_d.r.overflow_sense_relay = 1'b1; // R13
            st_d.r.overflow_sense_companion = 1'b1;
        end
        if (rise[`HCSS_P_PM_LAST] && st_q.r.overflow_sense_relay)
        begin
            st_d.r.last_line_relay = 1'b1; // R14
        end
        if (rise[`HCSS_P_CB_OVF] && st_q.r.last_line_relay && st_q.ctrl[`HCSS_CTRL_NI_OF]
            && !st_q.r.heading_seen_latch && !st_q.r.skip_one_request
            && !st_q.r.all_skips_relay)
        begin
            st_d.r.overflow_nonindicate_relay = 1'b1; // R15 R16 R23
        end
        if (rise[`HCSS_P_PM_OVF] && st_q.r.overflow_nonindicate_relay)
        begin
            st_d.r.skip_one_request = 1'b1; // R17
            st_d.r.skip_two_request = 1'b1;
        end

        // skip drive
        if (rise[`HCSS_P_CB_SKIP] && (st_q.r.skip_one_request || st_q.r.skip_two_request
            || st_q.r.overflow_nonindicate_relay))
        begin
            st_d.r.all_skips_relay = 1'b1; // R10
        end
        if (rise[`HCSS_P_CB_START] && st_q.r.all_skips_relay && !st_q.r.high_speed_stop)
        begin
            st_d.r.skip_start_relay = 1'b1; // R10
        end
        if (rise[`HCSS_P_CARR_CB] && pins[`HCSS_P_BRUSH1] && st_q.r.skip_start_relay
            && st_q.r.skip_one_request && st_q.r.skip_two_request)
        begin
            st_d.r.past_first_latch = 1'b1; // R20 R17
        end
        // stop on channel 2 for skip-to-2, channel 1 for a lone skip-to-1
        if (rise[`HCSS_P_CARR_CB] && st_q.r.skip_start_relay
            && ((pins[`HCSS_P_BRUSH2] && st_q.r.skip_two_request
            && (!st_q.r.skip_one_request || st_q.r.past_first_latch))
            || (pins[`HCSS_P_BRUSH1] && st_q.r.skip_one_request
            && !st_q.r.skip_two_request)))
        begin
            st_d.r.high_speed_stop = 1'b1; // R12 R20
        end

        // write channel
        if (s_axi_awvalid && !st_q.aw_got)
        begin
            st_d.aw_got = 1'b1;
            st_d.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_got)
        begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wlane0 = s_axi_wstrb[0];
        end
        if (st_q.bvalid && s_axi_bready)
        begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid)
        begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = `HCSS_RESP_SLVERR;
            if (reg_sel(st_q.waddr) != 2'h0)
            begin
                st_d.bresp = `HCSS_RESP_OKAY;
            end
            if (reg_sel(st_q.waddr) == 2'h1 && st_q.wlane0)
            begin
                st_d.ctrl = st_q.wdata[`HCSS_CTRL_W-1:0];
            end
        end

        // read channel
        if (st_q.rvalid && s_axi_rready)
        begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_q.rvalid)
        begin
            st_d.rvalid = 1'b1;
            st_d.rdata = 32'h0;
            st_d.rresp = `HCSS_RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                2'h1: st_d.rdata = {{(32 - `HCSS_CTRL_W){1'b0}}, st_q.ctrl};
                2'h2: st_d.rdata = {{(32 - `HCSS_STAT_W){1'b0}}, st_q.r};
                default: st_d.rresp = `HCSS_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= '0;
            st_q.ctrl <= `HCSS_CTRL_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign force_print_relay = st_q.r.heading_hold_relay || st_q.ctrl[`HCSS_CTRL_LIST]; // R03
    assign program_level_relays = side_pins[0] && !st_q.r.program_suspend_relay; // R05
    assign unequal_compare_out = side_pins[1]; // R05
    assign first_card_out = side_pins[2];
    assign run_heading_relay = st_q.r.run_heading_relay;
    // overflow skips run on the low-speed clutch path
    assign speed_interposer_magnet = st_q.r.skip_start_relay && !st_q.r.high_speed_stop
        && !st_q.r.overflow_sense_companion; // R11
    assign carriage_clutch_magnet = st_q.r.skip_start_relay && !st_q.r.high_speed_stop
        && (st_q.r.overflow_sense_companion
        || (speed_interposer_magnet && pins[`HCSS_P_SHIFTED])); // R11 R19
    assign high_speed_stop = st_q.r.high_speed_stop;
    assign s_axi_awready = !st_q.aw_got;
    assign s_axi_wready = !st_q.w_got;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_HOLD_SETS: assert property (rise[`HCSS_P_CB_HEAD] && st_q.r.heading_seen_latch
        |=> st_q.r.heading_hold_relay && st_q.r.run_heading_relay) else $error("hold not set"); // R02
    AST_FORCE_PRINT: assert property (st_q.r.heading_hold_relay |-> force_print_relay) // R03
        else $error("heading card not forced to print");
    AST_SUSPEND: assert property (st_q.r.program_suspend_relay |-> !program_level_relays) // R05
        else $error("program level passed during suspend");
    AST_BODY_BLOCK: assert property (st_q.r.heading_seen_latch |=> !st_q.r.body_card_relay) // R06
        else $error("body relay set under heading");
    AST_HOLD_DROP: assert property (rise[`HCSS_P_PM_190] && !st_q.r.heading_seen_latch // R07
        && !rise[`HCSS_P_CB_HEAD] |=> !st_q.r.heading_hold_relay) else $error("hold not dropped");
    AST_SKIP_TWO: assert property (rise[`HCSS_P_PM_SKIP] && !st_q.r.heading_hold_relay // R09
        && st_q.r.body_card_relay && !st_q.r.skip_two_issued |=> st_q.r.skip_two_request)
        else $error("skip-to-2 not issued");
    AST_START: assert property (rise[`HCSS_P_CB_START] && st_q.r.all_skips_relay // R10
        && !st_q.r.high_speed_stop |=> st_q.r.skip_start_relay ##1 st_q.r.skip_start_relay
        || st_q.r.high_speed_stop) else $error("skip start not held");
    AST_CLUTCH: assert property (carriage_clutch_magnet && !st_q.r.overflow_sense_companion // R11
        |-> speed_interposer_magnet) else $error("clutch without interposer");
    AST_STOP_TWO: assert property (rise[`HCSS_P_CARR_CB] && pins[`HCSS_P_BRUSH2] // R12
        && st_q.r.skip_start_relay && st_q.r.skip_two_request && !st_q.r.skip_one_request
        |=> st_q.r.high_speed_stop) else $error("no stop at channel 2");
    AST_PAST_ONE: assert property (rise[`HCSS_P_CARR_CB] && pins[`HCSS_P_BRUSH1] // R20
        && !pins[`HCSS_P_BRUSH2] && st_q.r.skip_start_relay && st_q.r.skip_one_request
        && st_q.r.skip_two_request && !st_q.r.high_speed_stop
        |=> st_q.r.past_first_latch && !st_q.r.high_speed_stop) else $error("stopped at 1");
    AST_OVF_SUPP: assert property (st_q.r.all_skips_relay // R23
        |=> !$rose(st_q.r.overflow_nonindicate_relay)) else $error("overflow during skip");

    COV_SKIP_TWO: cover property (st_q.r.skip_two_request && !st_q.r.skip_one_request
        ##[1:1000] st_q.r.high_speed_stop);
    COV_PAST_ONE: cover property ($rose(st_q.r.past_first_latch));
    COV_OVERFLOW: cover property ($rose(st_q.r.overflow_nonindicate_relay));

endmodule

// >>> inc/hcss_defines.svh
// constants for the heading control skip sequencer
// assumes a 20 MHz aclk and a 32-bit AXI4-Lite register bus
`ifndef HCSS_DEFINES_SVH
`define HCSS_DEFINES_SVH

// ****************************************************************
// machine pin vector layout
// ****************************************************************
`define HCSS_PIN_W 23
`define HCSS_P_HEAD_X 0
`define HCSS_P_CF_RELEASE 1
`define HCSS_P_CB_HEAD 2
`define HCSS_P_CF_THIRD 3
`define HCSS_P_CB_SUSP_END 4
`define HCSS_P_CF_BODY 5
`define HCSS_P_CF_FEED 6
`define HCSS_P_MLP 7
`define HCSS_P_PM_190 8
`define HCSS_P_PM_SKIP 9
`define HCSS_P_CB_SKIP 10
`define HCSS_P_CB_START 11
`define HCSS_P_CB_OVF 12
`define HCSS_P_PM_OVF 13
`define HCSS_P_PM_LAST 14
`define HCSS_P_CARR_CB 15
`define HCSS_P_STOP_REL 16
`define HCSS_P_BRUSH1 17
`define HCSS_P_BRUSH2 18
`define HCSS_P_BRUSH12 19
`define HCSS_P_FCM 20
`define HCSS_P_SHIFTED 21
`define HCSS_P_CARDS_OUT 22

// ****************************************************************
// register map
// ****************************************************************
`define HCSS_OFS_CTRL 8'h00
`define HCSS_OFS_STATUS 8'h04
`define HCSS_CTRL_W 3
`define HCSS_CTRL_HEAD_EN 0
`define HCSS_CTRL_NI_OF 1
`define HCSS_CTRL_LIST 2
`define HCSS_CTRL_RST 3'h1
`define HCSS_STAT_W 17
`define HCSS_RESP_OKAY 2'h0
`define HCSS_RESP_SLVERR 2'h2

`endif

// >>> inc/hcss_pkg.sv
// types of the heading control skip sequencer
// assumes hcss_defines.svh is on the include path
`include "hcss_defines.svh"
package hcss_pkg;

    // relay and latch states, bit 0 is past_first_latch
    typedef struct packed {
        logic heading_seen_latch;
        logic heading_hold_relay;
        logic run_heading_relay;
        logic program_suspend_relay;
        logic feed_cycle_companion;
        logic body_card_relay;
        logic skip_two_issued;
        logic skip_one_request;
        logic skip_two_request;
        logic all_skips_relay;
        logic skip_start_relay;
        logic high_speed_stop;
        logic overflow_sense_relay;
        logic overflow_sense_companion;
        logic last_line_relay;
        logic overflow_nonindicate_relay;
        logic past_first_latch;
    } hcss_relay_t;

    typedef struct packed {
        logic [`HCSS_PIN_W-1:0] prev;
        hcss_relay_t r;
        logic [`HCSS_CTRL_W-1:0] ctrl;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } hcss_state_t;

endpackage

// >>> verilog/hcss_pin_sync.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous machine contacts on every bit of pin_in
`timescale 1ns/1ns
module hcss_pin_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;
    } hcss_sync_t;

    hcss_sync_t st_q;
    hcss_sync_t st_d;

    // a bit moves only once the second and third stages agree
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.filt = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.filt);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign pin_out = st_q.filt;

endmodule

// >>> bench/hcss_far_side.sv
// carriage model: tape brushes, carriage breaker, interposer contact, stop release
// assumes the bench drives the card feed and print cams itself
`timescale 1ns/1ns
module hcss_far_side (
    input wire logic aclk,
    input wire logic space,
    input wire logic interposer,
    input wire logic clutch,
    input wire logic stopped,
    output logic carr_cb,
    output logic brush1,
    output logic brush2,
    output logic brush12,
    output logic shifted,
    output logic stop_rel,
    output logic [3:0] line
);
    logic [4:0] ph = 5'h0;
    logic [3:0] sh = 4'h0;
    int held = 0;
    initial {line, carr_cb, shifted, stop_rel} = '0;
    // twelve-line loop: ch1 at 0, ch2 at 4 and 8, ch12 at 6
    assign brush1 = (line == 4'h0);
    assign brush2 = (line == 4'h4) || (line == 4'h8);
    assign brush12 = (line == 4'h6);
    // one line is 32 cycles, breaker closed in its second half, still when idle
    always @(posedge aclk)
    begin
        sh <= {sh[2:0], interposer};
        shifted <= sh[3];
        if (ph != 5'h0 || clutch || space)
        begin
            ph <= ph + 5'h1;
            if (ph == 5'h0)
                line <= (line == 4'hb) ? 4'h0 : line + 4'h1;
        end
        carr_cb <= ph[4];
        held <= stopped ? held + 1 : 0;
        stop_rel <= (held >= 24) && (held < 32);
    end
endmodule

// >>> bench/test_heading_control_skip_sequencer.sv
// self-checking bench for hcss_top: registers, heading control, skips
// assumes hcss_far_side stands for the carriage; cams are pulsed here
`timescale 1ns/1ns
`include "hcss_defines.svh"
module test_heading_control_skip_sequencer;
    typedef struct packed {
        logic wr;
        logic [7:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [1:0] resp;
        logic [31:0] rd;
    } hcss_row_t;
    hcss_row_t rows [9] = '{
        '{1'h0, 8'h00, 32'h0, 4'h0, 2'h0, 32'h1}, '{1'h0, 8'h04, 32'h0, 4'h0, 2'h0, 32'h0},
        '{1'h1, 8'h00, 32'h6, 4'hf, 2'h0, 32'h0}, '{1'h0, 8'h00, 32'h0, 4'h0, 2'h0, 32'h6},
        '{1'h1, 8'h00, 32'h1, 4'h0, 2'h0, 32'h0}, '{1'h0, 8'h00, 32'h0, 4'h0, 2'h0, 32'h6},
        '{1'h0, 8'h08, 32'h0, 4'h0, 2'h2, 32'h0}, '{1'h1, 8'h0c, 32'h1, 4'hf, 2'h2, 32'h0},
        '{1'h1, 8'h00, 32'h1, 4'hf, 2'h0, 32'h0}};
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [22:0] pins = 23'h0;
    logic [22:0] machine_pins;
    logic program_level_request = 1'h0, unequal_compare_in = 1'h0, first_card_in = 1'h0;
    logic space = 1'h0;
    logic force_print_relay, program_level_relays, unequal_compare_out, first_card_out;
    logic run_heading_relay, speed_interposer_magnet, carriage_clutch_magnet, high_speed_stop;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rv;
    logic cb, b1, b2, b12, shf, srel;
    logic [3:0] line;
    int miscompares = 0;
    int checks_done = 0;
    int n;

    initial forever #25 aclk = ~aclk;

    hcss_top dut_u (.aclk, .aresetn, .machine_pins, .program_level_request,
        .unequal_compare_in, .first_card_in, .force_print_relay, .program_level_relays,
        .unequal_compare_out, .first_card_out, .run_heading_relay, .speed_interposer_magnet,
        .carriage_clutch_magnet, .high_speed_stop, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    hcss_far_side far_u (.aclk, .space, .interposer(speed_interposer_magnet),
        .clutch(carriage_clutch_magnet), .stopped(high_speed_stop), .carr_cb(cb),
        .brush1(b1), .brush2(b2), .brush12(b12), .shifted(shf), .stop_rel(srel), .line);

    assign machine_pins = {pins[22], shf, pins[20], b12, b2, b1, srel, cb, pins[14:0]};

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic expired;
        chk(32'h0, 32'h1);
        results();
    endtask

    task automatic ax(input logic wr, logic [7:0] a, logic [31:0] d, logic [3:0] s,
        output logic [31:0] q, logic [1:0] r);
        r = 2'h3;
        q = 32'h0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        for (n = 0; n < 64 && r === 2'h3; n++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'h0;
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rready && s_axi_rvalid)
                q = s_axi_rdata;
            if (s_axi_rready && s_axi_rvalid)
                r = s_axi_rresp;
            if (s_axi_bready && s_axi_bvalid)
                r = s_axi_bresp;
        end
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
        if (r === 2'h3)
            expired();
    endtask

    // long enough for the pin filter and edge detect
    task automatic pulse(input int i);
        pins[i] <= 1'h1;
        repeat (8) @(posedge aclk);
        pins[i] <= 1'h0;
        repeat (8) @(posedge aclk);
    endtask

    task automatic st(input logic [16:0] m, e);
        ax(1'h0, 8'h04, 32'h0, 4'h0, rv, rsp);
        chk({15'h0, rv[16:0] & m}, {15'h0, e});
    endtask

    task automatic wstop(input logic lvl);
        for (n = 0; n < 3000 && high_speed_stop !== lvl; n++)
            @(posedge aclk);
        if (n == 3000)
            expired();
    endtask

    task automatic skip_run;
        pulse(`HCSS_P_CB_SKIP);
        pulse(`HCSS_P_CB_START);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk({26'h0, force_print_relay, program_level_relays, run_heading_relay,
            speed_interposer_magnet, carriage_clutch_magnet, high_speed_stop}, 32'h0);
        foreach (rows[k])
        begin
            ax(rows[k].wr, rows[k].a, rows[k].d, rows[k].s, rv, rsp);
            chk({30'h0, rsp}, {30'h0, rows[k].resp});
            chk(rv, rows[k].rd);
        end
        $display("test registers done");
        pins[`HCSS_P_MLP] <= 1'h1;
        pulse(`HCSS_P_CF_FEED);
        st(17'h01000, 17'h0);
        pins[`HCSS_P_MLP] <= 1'h0;
        program_level_request <= 1'h1;
        unequal_compare_in <= 1'h1;
        first_card_in <= 1'h1;
        pulse(`HCSS_P_HEAD_X);
        st(17'h10000, 17'h10000);
        pulse(`HCSS_P_CB_HEAD);
        st(17'h1c000, 17'h1c000);
        chk({31'h0, force_print_relay}, 32'h1);
        pulse(`HCSS_P_CF_FEED);
        pulse(`HCSS_P_CF_BODY);
        st(17'h00800, 17'h0);
        pulse(`HCSS_P_CF_THIRD);
        st(17'h02000, 17'h02000);
        chk({29'h0, program_level_relays, unequal_compare_out, first_card_out}, 32'h3);
        pulse(`HCSS_P_CF_RELEASE);
        st(17'h10000, 17'h0);
        pulse(`HCSS_P_PM_190);
        st(17'h0c000, 17'h04000);
        pulse(`HCSS_P_CF_FEED);
        pulse(`HCSS_P_CF_BODY);
        st(17'h01800, 17'h01800);
        pulse(`HCSS_P_PM_SKIP);
        st(17'h00500, 17'h00500);
        pulse(`HCSS_P_CB_SKIP);
        st(17'h00080, 17'h00080);
        pulse(`HCSS_P_CB_START);
        st(17'h00040, 17'h00040);
        chk({30'h0, speed_interposer_magnet, carriage_clutch_magnet}, 32'h3);
        wstop(1'h1);
        chk({28'h0, line}, 32'h4);
        wstop(1'h0);
        st(17'h003e0, 17'h0);
        $display("test heading skip done");
        ax(1'h1, 8'h00, 32'h3, 4'hf, rv, rsp);
        repeat (2)
        begin
            space <= 1'h1;
            @(posedge aclk);
            space <= 1'h0;
            repeat (40) @(posedge aclk);
        end
        st(17'h00018, 17'h00018);
        pulse(`HCSS_P_PM_LAST);
        st(17'h00004, 17'h00004);
        pulse(`HCSS_P_CB_OVF);
        st(17'h00002, 17'h00002);
        pulse(`HCSS_P_PM_OVF);
        st(17'h00300, 17'h00300);
        skip_run();
        chk({30'h0, speed_interposer_magnet, carriage_clutch_magnet}, 32'h1);
        for (n = 0; n < 2000 && line !== 4'h1; n++)
            @(posedge aclk);
        if (n == 2000)
            expired();
        st(17'h00001, 17'h00001);
        wstop(1'h1);
        chk({28'h0, line}, 32'h4);
        wstop(1'h0);
        $display("test overflow done");
        pulse(`HCSS_P_HEAD_X);
        pulse(`HCSS_P_CB_HEAD);
        pulse(`HCSS_P_PM_SKIP);
        st(17'h00500, 17'h0);
        pulse(`HCSS_P_FCM);
        st(17'h00300, 17'h00200);
        skip_run();
        wstop(1'h1);
        chk({28'h0, line}, 32'h0);
        wstop(1'h0);
        $display("test missing detail done");
        results();
    end
endmodule
